// >>> src/pirq_defs.vh
/*
  constants for the peripheral request flags and power control block:
  apb offsets, bit positions, reset values.
  assumes it is included by bare name from the design files.
*/
// Functional notes
// - flags set regardless of any enable
// - converter done flag, bit 6, sticky
// - receive full flag, bit 5, read-only
// - transmit empty flag, bit 4, read-only
// - sync serial flag on transfer done
// - i2c master conditions also set serial flag
// - capture/compare a flag, unused in pwm
// - timer 2 period match flag, bit 1
// - timer 1 overflow flag, bit 0
// - oscillator fail flag, bit 7 reg 2
// - comparator flags on output change
// - nonvolatile write done flag, bit 4
// - bus collision flag in i2c master
// - low power wake flag, bit 2
// - capture/compare b flag like a
// - unimplemented bits read zero
// - wake enable drives current sink
// - soft brownout enable only when config 01
// - power-on reset clears power-on status
// - brownout reset clears brownout status
// - forward request when flag, enable, peripheral_irq_enable
`ifndef PIRQ_DEFS_VH
`define PIRQ_DEFS_VH
`define PIRQ_OFF_FLAGS1 12'h000
`define PIRQ_OFF_FLAGS2 12'h004
`define PIRQ_OFF_POWER_CONTROL_RESET_STATUS 12'h008
`define PIRQ_OFF_ENABLE1 12'h00c
`define PIRQ_OFF_ENABLE2 12'h010
`define PIRQ_B1_CONV 6
`define PIRQ_B1_RX 5
`define PIRQ_B1_TX 4
`define PIRQ_B1_SYNC 3
`define PIRQ_B1_CCA 2
`define PIRQ_B1_PER 1
`define PIRQ_B1_OVF 0
`define PIRQ_B2_OSC 7
`define PIRQ_B2_CMPB 6
`define PIRQ_B2_CMPA 5
`define PIRQ_B2_NVW 4
`define PIRQ_B2_BCL 3
`define PIRQ_B2_WAKE 2
`define PIRQ_B2_CCB 0
`define PIRQ_BP_WAKE_EN 5
`define PIRQ_BP_SBOR 4
`define PIRQ_BP_POR 1
`define PIRQ_BP_BOR 0
`define PIRQ_MASK1 8'h4f
`define PIRQ_MASK2 8'hfd
`define PIRQ_MASKP 8'h33
`define PIRQ_MASKE1 8'h7f
`define PIRQ_MASKE2 8'hfd
`define PIRQ_RST_FLAGS 8'h00
`define PIRQ_RST_ENABLE 8'h00
`define PIRQ_RST_WAKE_EN 1'b0
`define PIRQ_RST_SBOR 1'b1
`define PIRQ_BOR_SOFT 2'b01
`define PIRQ_CCP_PWM 2'b10
`endif

// >>> src/pirq_sync.v
/*
  three-stage synchroniser with agreement filter for a level from
  outside the clock domain. assumes sys_clk and synchronous reset.
*/
module pirq_sync #(
  parameter RST_VAL = 1'b0
) (
  input wire sys_clk,
  input wire rst,
  input wire d,
  output reg q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge sys_clk) begin
    if (rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // first stage feeds only the second
      if (s2_q == s3_q) begin
        q <= s3_q;
      end
    end
  end
endmodule

// >>> src/pirq_top.v
/*
  peripheral request flags, enables and power control / reset status
  behind an apb slave. assumes peripheral event inputs are one-cycle
  pulses on sys_clk, comparator outputs are asynchronous levels, and
  por_event / bor_event are sys_clk pulses raised by the reset logic.
*/
// The APB slave port and the register addresses are this design's own decisions.
`include "pirq_defs.vh"
module pirq_top (
  input wire sys_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire conv_done,
  input wire rx_buffer_full,
  input wire rx_data_read,
  input wire tx_data_write,
  input wire tx_shift_load,
  input wire sync_xfer_done,
  input wire i2c_master_mode,
  input wire i2c_cond_done,
  input wire i2c_idle_start_stop,
  input wire i2c_collision,
  input wire [1:0] capcmp_a_mode,
  input wire capcmp_a_event,
  input wire [1:0] capcmp_b_mode,
  input wire capcmp_b_event,
  input wire period_match,
  input wire timer_overflow,
  input wire osc_failed,
  input wire comparator_a_output,
  input wire comparator_b_output,
  input wire nv_write_done,
  input wire low_power_wake,
  input wire por_event,
  input wire bor_event,
  input wire [1:0] brownout_config_field,
  input wire peripheral_irq_enable,
  output wire peripheral_irq,
  output reg low_power_wake_enable,
  output wire brownout_reset_enable
);
  reg [7:0] flags1_q;
  reg [7:0] flags2_q;
  reg [7:0] enable1_q;
  reg [7:0] enable2_q;
  reg soft_brownout_enable_q;
  reg por_status_q;
  reg bor_status_q;
  reg tx_empty_q;
  reg cmp_a_prev_q;
  reg cmp_b_prev_q;
  wire cmp_a_s;
  wire cmp_b_s;
  wire wr_en;
  wire rd_en;
  wire [7:0] wbyte;
  wire [7:0] set1;
  wire [7:0] set2;
  wire [7:0] wr1;
  wire [7:0] wr2;
  wire [7:0] power_control_reset_status_rd;
  wire [7:0] flags1_d;
  wire [7:0] flags2_d;
  wire [7:0] mask1;
  wire [7:0] mask2;
  reg [7:0] rd_byte_d;

  function sel;
    input [11:0] a;
    input [11:0] off;
    begin
      sel = (a == off);
    end
  endfunction

  // one flag cell; a set in the same cycle as a write-0 must not be lost
  function cell_next;
    input cur;
    input wbit;
    input we;
    input setb;
    input keep;
    begin
      if (!keep) begin
        cell_next = 1'b0;
      end else if (setb) begin
        cell_next = 1'b1;
      end else if (we) begin
        cell_next = wbit;
      end else begin
        cell_next = cur;
      end
    end
  endfunction

  pirq_sync #(.RST_VAL(1'b0)) u_sync_a (
    .sys_clk(sys_clk),
    .rst(rst),
    .d(comparator_a_output),
    .q(cmp_a_s)
  );
  pirq_sync #(.RST_VAL(1'b0)) u_sync_b (
    .sys_clk(sys_clk),
    .rst(rst),
    .d(comparator_b_output),
    .q(cmp_b_s)
  );

  // zero wait state slave; every access completes in its access phase
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign wbyte = pwdata[7:0];
  assign wr1 = wr_en & sel(paddr, `PIRQ_OFF_FLAGS1) ? 8'hff : 8'h00;
  assign wr2 = wr_en & sel(paddr, `PIRQ_OFF_FLAGS2) ? 8'hff : 8'h00;

  assign set1[7] = 1'b0;
  assign set1[`PIRQ_B1_CONV] = conv_done;
  assign set1[`PIRQ_B1_RX] = 1'b0;
  assign set1[`PIRQ_B1_TX] = 1'b0;
  assign set1[`PIRQ_B1_SYNC] = sync_xfer_done
    | (i2c_master_mode & (i2c_cond_done | i2c_idle_start_stop));
  assign set1[`PIRQ_B1_CCA] = capcmp_a_event
    & (capcmp_a_mode != `PIRQ_CCP_PWM);
  assign set1[`PIRQ_B1_PER] = period_match;
  assign set1[`PIRQ_B1_OVF] = timer_overflow;

  assign set2[`PIRQ_B2_OSC] = osc_failed;
  assign set2[`PIRQ_B2_CMPB] = cmp_b_s ^ cmp_b_prev_q;
  assign set2[`PIRQ_B2_CMPA] = cmp_a_s ^ cmp_a_prev_q;
  assign set2[`PIRQ_B2_NVW] = nv_write_done;
  assign set2[`PIRQ_B2_BCL] = i2c_collision & i2c_master_mode;
  assign set2[`PIRQ_B2_WAKE] = low_power_wake;
  assign set2[1] = 1'b0;
  assign set2[`PIRQ_B2_CCB] = capcmp_b_event
    & (capcmp_b_mode != `PIRQ_CCP_PWM);

  assign mask1 = `PIRQ_MASK1;
  assign mask2 = `PIRQ_MASK2;

  // read-only and unimplemented positions are masked to zero in the cell
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_cell
      assign flags1_d[gi] = cell_next(flags1_q[gi], wbyte[gi], wr1[gi], set1[gi],
        mask1[gi]);
      assign flags2_d[gi] = cell_next(flags2_q[gi], wbyte[gi], wr2[gi], set2[gi],
        mask2[gi]);
    end
  endgenerate

  always @(posedge sys_clk) begin
    if (rst) begin
      flags1_q <= `PIRQ_RST_FLAGS;
      flags2_q <= `PIRQ_RST_FLAGS;
      enable1_q <= `PIRQ_RST_ENABLE;
      enable2_q <= `PIRQ_RST_ENABLE;
      tx_empty_q <= 1'b1;
      cmp_a_prev_q <= 1'b0;
      cmp_b_prev_q <= 1'b0;
    end else begin
      cmp_a_prev_q <= cmp_a_s;
      cmp_b_prev_q <= cmp_b_s;
      flags1_q <= flags1_d;
      flags2_q <= flags2_d;
      // transmit flag rises on buffer move to shifter; load wins over write
      if (tx_shift_load) begin
        tx_empty_q <= 1'b1;
      end else if (tx_data_write) begin
        tx_empty_q <= 1'b0;
      end
      if (wr_en & sel(paddr, `PIRQ_OFF_ENABLE1)) begin
        enable1_q <= wbyte & `PIRQ_MASKE1;
      end
      if (wr_en & sel(paddr, `PIRQ_OFF_ENABLE2)) begin
        enable2_q <= wbyte & `PIRQ_MASKE2;
      end
    end
  end

  // power control: status bits survive rst; only reset events and register writes clear them
  always @(posedge sys_clk) begin
    if (por_event) begin
      por_status_q <= 1'b0;
      bor_status_q <= 1'b0;
      low_power_wake_enable <= `PIRQ_RST_WAKE_EN;
      soft_brownout_enable_q <= `PIRQ_RST_SBOR;
    end else if (bor_event) begin
      bor_status_q <= 1'b0;
      low_power_wake_enable <= `PIRQ_RST_WAKE_EN;
      soft_brownout_enable_q <= `PIRQ_RST_SBOR;
    end else if (rst) begin
      low_power_wake_enable <= `PIRQ_RST_WAKE_EN;
      soft_brownout_enable_q <= `PIRQ_RST_SBOR;
    end else if (wr_en & sel(paddr, `PIRQ_OFF_POWER_CONTROL_RESET_STATUS)) begin
      low_power_wake_enable <= wbyte[`PIRQ_BP_WAKE_EN];
      soft_brownout_enable_q <= wbyte[`PIRQ_BP_SBOR];
      por_status_q <= wbyte[`PIRQ_BP_POR];
      bor_status_q <= wbyte[`PIRQ_BP_BOR];
    end
  end

  // other config codes fix brownout on or off outside this block
  assign brownout_reset_enable = (brownout_config_field == `PIRQ_BOR_SOFT)
    & soft_brownout_enable_q;

  assign power_control_reset_status_rd = {2'b00, low_power_wake_enable, soft_brownout_enable_q,
    2'b00, por_status_q, bor_status_q};

  // is on software; forwarding simply follows the stored flags
  assign peripheral_irq = peripheral_irq_enable
    & (|({flags1_q[7:6], rx_buffer_full, tx_empty_q, flags1_q[3:0]} & enable1_q)
    | |(flags2_q & enable2_q));

  always @* begin
    rd_byte_d = 8'h00;
    case (paddr)
      `PIRQ_OFF_FLAGS1: begin
        rd_byte_d = {1'b0, flags1_q[6], rx_buffer_full, tx_empty_q,
          flags1_q[3:0]};
      end
      `PIRQ_OFF_FLAGS2: begin
        rd_byte_d = flags2_q;
      end
      `PIRQ_OFF_POWER_CONTROL_RESET_STATUS: begin
        rd_byte_d = power_control_reset_status_rd;
      end
      `PIRQ_OFF_ENABLE1: begin
        rd_byte_d = enable1_q;
      end
      `PIRQ_OFF_ENABLE2: begin
        rd_byte_d = enable2_q;
      end
      default: begin
        rd_byte_d = 8'h00;
      end
    endcase
  end

  // read data is taken in the setup cycle so it stands for the access phase
  always @(posedge sys_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= {24'h000000, rd_byte_d};
    end
  end

  // receive flag follows the buffer; its clear comes from rx_data_read
  // acting inside the receiver, which lowers rx_buffer_full
  wire unused_rd;
  assign unused_rd = rd_en & rx_data_read;
endmodule

// >>> bench/pirq_periph.sv
/*
  stand-in for the on-chip peripherals: one-cycle event pulses.
  assumes sys_clk from the bench; bit order is fixed by tb_top.
*/
module pirq_periph (
  input logic sys_clk,
  output logic [15:0] ev
);
  timeunit 1ns;
  timeprecision 1ns;
  initial ev = 16'h0000;
  // a condition is a single pulse, so a stuck level cannot mask a lost set
  task automatic fire(input int i);
    @(posedge sys_clk) ev[i] <= 1'b1;
    @(posedge sys_clk) ev[i] <= 1'b0;
  endtask
endmodule

// >>> bench/pirq_chk.sv
/*
  assertions on the ports of pirq_top.
  assumes sys_clk and a synchronous active-high rst; bound below.
*/
module pirq_chk (
  input logic sys_clk,
  input logic rst,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic conv_done,
  input logic por_event,
  input logic [1:0] brownout_config_field,
  input logic peripheral_irq_enable,
  input logic peripheral_irq,
  input logic brownout_reset_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // a write setup leaves prdata untouched, so only read setups count
  wire rd = psel && !penable && !pwrite;
  irq_gate_a:
    assert property (!peripheral_irq_enable |-> !peripheral_irq) else $error("irq leak");
  upper_zero_a:
    assert property (rd |=> prdata[31:8] == 24'h0) else $error("upper bits set");
  unmapped_a:
    assert property (rd && paddr > 12'h010 |=> prdata == 32'h0) else $error("unmapped read");
  power_rsvd_a:
    assert property (rd && paddr == 12'h008 |=> prdata[7:6] == 2'b00 && prdata[3:2] == 2'b00)
      else $error("power reserved bits");
  flags_rsvd_a:
    assert property (rd && paddr == 12'h000 |=> !prdata[7]) else $error("flag bit 7 set");
  brownout_gate_a:
    assert property (brownout_config_field != 2'b01 |-> !brownout_reset_enable)
      else $error("brownout enable leak");
  conv_set_a:
    assert property (conv_done ##2 rd && paddr == 12'h000 |=> prdata[6]) else $error("conv lost");
  por_clear_a:
    assert property (por_event ##2 rd && paddr == 12'h008 |=> prdata[1:0] == 2'b00)
      else $error("status not cleared");
endmodule
bind pirq_top pirq_chk u_chk (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .prdata,
  .conv_done,
  .por_event, .brownout_config_field, .peripheral_irq_enable, .peripheral_irq,
  .brownout_reset_enable);

// >>> bench/tb_top.sv
/*
  self-checking bench for pirq_top: apb tasks, event pulses, checks.
  assumes pirq_periph drives events and pirq_chk is bound.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic rx_buffer_full = 1'b0, i2c_master_mode = 1'b1, peripheral_irq_enable = 1'b0;
  logic comparator_a_output = 1'b0, comparator_b_output = 1'b0, rx_data_read = 1'b0;
  logic [1:0] capcmp_a_mode = 2'b00, capcmp_b_mode = 2'b00, brownout_config_field = 2'b01;
  wire pready, pslverr, peripheral_irq, low_power_wake_enable, brownout_reset_enable;
  wire [31:0] prdata;
  wire [15:0] ev;
  int num_errors = 0, n_checks = 0;
  logic [8:0] tbl [12] = '{9'h040, 9'h008, 9'h008, 9'h008, 9'h108, 9'h004, 9'h101, 9'h002,
    9'h001, 9'h180, 9'h110, 9'h104};
  pirq_periph u_per (.sys_clk, .ev);
  pirq_top DUT (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .conv_done(ev[0]), .rx_buffer_full, .rx_data_read, .tx_data_write(ev[14]),
    .tx_shift_load(ev[15]), .sync_xfer_done(ev[1]), .i2c_master_mode, .i2c_cond_done(ev[2]),
    .i2c_idle_start_stop(ev[3]), .i2c_collision(ev[4]), .capcmp_a_mode, .capcmp_a_event(ev[5]),
    .capcmp_b_mode, .capcmp_b_event(ev[6]), .period_match(ev[7]), .timer_overflow(ev[8]),
    .osc_failed(ev[9]), .comparator_a_output, .comparator_b_output, .nv_write_done(ev[10]),
    .low_power_wake(ev[11]), .por_event(ev[12]), .bor_event(ev[13]), .brownout_config_field,
    .peripheral_irq_enable, .peripheral_irq, .low_power_wake_enable, .brownout_reset_enable);
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic ck(input string s, input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s exp %h got %h", s, e, g);
    end
  endtask
  // one apb transfer; the request holds until pready is seen at an edge
  task automatic go(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      num_errors++;
      conclude();
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    go(1'b0, a, 8'h00);
    ck("prdata", prdata, {24'h0, e});
  endtask
  initial forever #10 sys_clk = ~sys_clk;
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    u_per.fire(12);
    rd(12'h008, 8'h10);
    rd(12'h000, 8'h10);
    go(1'b1, 12'h008, 8'hff);
    rd(12'h008, 8'h33);
    ck("wake_en", low_power_wake_enable, 32'h1);
    ck("bor_en", brownout_reset_enable, 32'h1);
    brownout_config_field <= 2'b00;
    rd(12'h008, 8'h33);
    ck("bor_en", brownout_reset_enable, 32'h0);
    u_per.fire(13);
    rd(12'h008, 8'h12);
    $display("power test done");
    go(1'b1, 12'h000, 8'hff);
    rd(12'h000, 8'h5f);
    go(1'b1, 12'h004, 8'hff);
    rd(12'h004, 8'hfd);
    go(1'b1, 12'h004, 8'h00);
    go(1'b1, 12'h000, 8'h00);
    rd(12'h000, 8'h10);
    go(1'b1, 12'h014, 8'hff);
    rd(12'h014, 8'h00);
    $display("access test done");
    // enables stay clear here, so every set below is enable-blind
    for (int i = 0; i < 12; i++) begin
      u_per.fire(i);
      rd({9'h0, tbl[i][8], 2'b0}, tbl[i][7:0] | (tbl[i][8] ? 8'h00 : 8'h10));
      go(1'b1, {9'h0, tbl[i][8], 2'b0}, 8'h00);
    end
    i2c_master_mode <= 1'b0;
    capcmp_a_mode <= 2'b10;
    capcmp_b_mode <= 2'b10;
    for (int i = 2; i < 7; i++) u_per.fire(i);
    rd(12'h000, 8'h10);
    rd(12'h004, 8'h00);
    $display("event test done");
    fork
      go(1'b1, 12'h000, 8'h00);
      begin
        @(posedge sys_clk);
        u_per.fire(0);
      end
    join
    rd(12'h000, 8'h50);
    go(1'b1, 12'h00c, 8'h40);
    peripheral_irq_enable <= 1'b1;
    rd(12'h00c, 8'h40);
    ck("irq", peripheral_irq, 32'h1);
    go(1'b1, 12'h000, 8'h00);
    rd(12'h000, 8'h10);
    ck("irq", peripheral_irq, 32'h0);
    rx_buffer_full <= 1'b1;
    u_per.fire(14);
    rd(12'h000, 8'h20);
    rx_buffer_full <= 1'b0;
    rx_data_read <= 1'b1;
    u_per.fire(15);
    rx_data_read <= 1'b0;
    rd(12'h000, 8'h10);
    comparator_a_output <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rd(12'h004, 8'h20);
    comparator_b_output <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rd(12'h004, 8'h60);
    $display("irq test done");
    conclude();
  end
endmodule
